/* File: host_port_pkg.sv */
// host_port_pkg: register map, field positions and reset values of the host port.
// assumes: used by host_port_regs_and_irq with package-qualified names only.
package host_port_pkg;

    // ----------------------------------------------------------------
    // direct register byte offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_INDEX = 4'h0;
    localparam logic [3:0] OFS_WINDOW = 4'h4;
    localparam logic [3:0] OFS_STREAM = 4'h8;
    localparam logic [3:0] OFS_IRQ = 4'hc;

    // ----------------------------------------------------------------
    // widths and layout
    // ----------------------------------------------------------------
    localparam int IND_W = 16;
    localparam int WORD_W = 32;
    localparam int NUM_EVT = 7;
    localparam int EN_LSB = 8;
    localparam int LEVEL_W = 4;
    localparam logic [3:0] BE_LOW_HALF = 4'h3;
    localparam logic [3:0] BE_HIGH_HALF = 4'hc;

    // event bit positions in the mask/status register
    localparam int EVT_SYNC = 0;
    localparam int EVT_STATS = 1;
    localparam int EVT_FINAL = 2;
    localparam int EVT_SERVICE = 3;
    localparam int EVT_FAULT = 4;
    localparam int EVT_HALT = 5;
    localparam int EVT_MEM = 6;

    // ----------------------------------------------------------------
    // shadowed indirect registers
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_MODE = 16'h0000;
    localparam logic [15:0] IDX_FIFO_CTL = 16'h0001;
    localparam int MODE_ENCODE_BIT = 7;
    localparam int MODE_IRQ_POL_BIT = 13;
    localparam int CTL_FILL_LSB = 0;
    localparam int CTL_DRAIN_LSB = 4;
    localparam logic [3:0] FILL_LEVEL_RST = 4'h8;
    localparam logic [3:0] DRAIN_LEVEL_RST = 4'h8;
    localparam logic MODE_ENCODE_RST = 1'b1;
    localparam logic IRQ_POL_RST = 1'b0;

    // ----------------------------------------------------------------
    // queue sizing
    // ----------------------------------------------------------------
    localparam int QUEUE_DEPTH = 512;
    localparam int LEVEL_STEP = 32;
    localparam int HALT_MARGIN = 32;

endpackage

/* File: host_port_regs_and_irq.sv */
// host_port_regs_and_irq: direct host registers, indirect index/window,
// stream queue behind the stream register and the event/irq logic.
// assumes: host bus strobes are synchronous to i_clk, one cycle per access;
// core-side signals come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// stream queue
// ----------------------------------------------------------------
module stream_queue #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    // occupancy
    output logic [$clog2(DEPTH+1)-1:0] o_count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } queue_s;

    queue_s q_q;
    queue_s q_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic do_push;
    logic do_pop;

    assign o_in_ready = (q_q.count != CW'(DEPTH));
    assign o_out_valid = (q_q.count != '0);
    assign o_out_data = mem[q_q.rd_ptr];
    assign o_count = q_q.count;
    assign do_push = i_in_valid && o_in_ready;
    assign do_pop = o_out_valid && i_out_ready;

    always_comb begin
        q_d = q_q;
        if (do_push) begin
            q_d.wr_ptr = (q_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : q_q.wr_ptr + 1'b1;
        end
        if (do_pop) begin
            q_d.rd_ptr = (q_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : q_q.rd_ptr + 1'b1;
        end
        q_d.count = q_q.count + CW'(do_push) - CW'(do_pop);
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    // storage has no reset; contents are undefined until written
    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem[q_q.wr_ptr] <= i_in_data;
        end
    end
endmodule

// ----------------------------------------------------------------
// register port top
// ----------------------------------------------------------------
module host_port_regs_and_irq #(
    parameter int QUEUE_DEPTH = host_port_pkg::QUEUE_DEPTH
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // host register bus
    input wire logic [3:0] i_host_addr,
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    input wire logic [3:0] i_host_be,
    input wire logic [31:0] i_host_wdata,
    output logic [31:0] o_host_rdata,
    output logic o_host_rvalid,
    // indirect register port to the codec core
    output logic [15:0] o_index_value,
    output logic o_ind_wr,
    output logic o_ind_rd,
    output logic [15:0] o_window_value,
    input wire logic [15:0] i_window_value,
    // encode stream from the core
    input wire logic i_core_wvalid,
    output logic o_core_wready,
    input wire logic [31:0] i_core_wdata,
    // decode stream to the core
    output logic o_core_rvalid,
    input wire logic i_core_rready,
    output logic [31:0] o_core_rdata,
    // event conditions from the core
    input wire logic i_sync_code_error,
    input wire logic i_stats_ready,
    input wire logic i_final_word,
    input wire logic i_memory_fault,
    // pins and mode
    output logic o_encode_mode,
    output logic o_host_irq_pin,
    output logic o_stats_ready_pin,
    output logic o_final_word_pin,
    output logic o_service_request_pin,
    output logic o_queue_fault_pin,
    output logic o_queue_halt_pin
);
    localparam int CW = $clog2(QUEUE_DEPTH+1);
    localparam int NE = host_port_pkg::NUM_EVT;
    localparam int LW = host_port_pkg::LEVEL_W;

    typedef struct packed {
        logic [15:0] index_value;
        logic [15:0] low_half;
        logic mode_encode;
        logic irq_polarity_select;
        logic [LW-1:0] fill_threshold_level;
        logic [LW-1:0] drain_threshold_level;
        logic [NE-1:0] enables;
        logic [NE-1:0] flags;
        logic [NE-1:0] cond_prev;
        logic [31:0] rdata;
        logic rvalid;
        logic irq_pin;
        logic stats_pin;
        logic final_pin;
        logic service_pin;
        logic halt_pin;
    } port_s;

    port_s s_q;
    port_s s_d;

    // ----------------------------------------------------------------
    // decode of host accesses
    // ----------------------------------------------------------------
    logic hit_index_wr;
    logic hit_window;
    logic hit_stream_wr;
    logic hit_stream_rd;
    logic hit_irq_wr;
    logic hit_irq_rd;
    logic low_only;
    logic stream_push;
    logic stream_pop;
    logic [31:0] push_word;

    assign hit_index_wr = i_host_wr && (i_host_addr == host_port_pkg::OFS_INDEX);
    assign hit_window = (i_host_wr || i_host_rd) && (i_host_addr == host_port_pkg::OFS_WINDOW);
    assign hit_stream_wr = i_host_wr && (i_host_addr == host_port_pkg::OFS_STREAM);
    assign hit_stream_rd = i_host_rd && (i_host_addr == host_port_pkg::OFS_STREAM);
    assign hit_irq_wr = i_host_wr && (i_host_addr == host_port_pkg::OFS_IRQ);
    assign hit_irq_rd = i_host_rd && (i_host_addr == host_port_pkg::OFS_IRQ);
    assign low_only = (i_host_be == host_port_pkg::BE_LOW_HALF);
    // the queue advances on every access except a low-half-only one, so half-word pairs form one word
    assign stream_push = hit_stream_wr && !low_only;
    assign stream_pop = hit_stream_rd && !low_only;
    assign push_word = (i_host_be == host_port_pkg::BE_HIGH_HALF) ?
        {i_host_wdata[31:16], s_q.low_half} : i_host_wdata;

    // ----------------------------------------------------------------
    // stream queue and its steering by mode
    // ----------------------------------------------------------------
    logic q_in_valid;
    logic q_in_ready;
    logic [31:0] q_in_data;
    logic q_out_valid;
    logic q_out_ready;
    logic [31:0] q_out_data;
    logic [CW-1:0] q_count;

    always_comb begin
        if (s_q.mode_encode) begin
            q_in_valid = i_core_wvalid;
            q_in_data = i_core_wdata;
            q_out_ready = stream_pop;
        end else begin
            q_in_valid = stream_push;
            q_in_data = push_word;
            q_out_ready = i_core_rready;
        end
    end

    stream_queue #(
        .WIDTH(host_port_pkg::WORD_W),
        .DEPTH(QUEUE_DEPTH)
    ) u_queue (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_in_valid(q_in_valid),
        .o_in_ready(q_in_ready),
        .i_in_data(q_in_data),
        .o_out_valid(q_out_valid),
        .i_out_ready(q_out_ready),
        .o_out_data(q_out_data),
        .o_count(q_count)
    );

    assign o_core_wready = s_q.mode_encode && q_in_ready;
    assign o_core_rvalid = !s_q.mode_encode && q_out_valid;
    assign o_core_rdata = q_out_data;

    // ----------------------------------------------------------------
    // queue conditions
    // ----------------------------------------------------------------
    logic [CW+LW-1:0] fill_mark;
    logic [CW+LW-1:0] drain_mark;
    logic [CW+LW-1:0] used_wide;
    logic [CW+LW-1:0] free_wide;
    logic service_now;
    logic halt_now;
    logic fault_now;

    assign used_wide = (CW+LW)'(q_count);
    assign free_wide = (CW+LW)'(QUEUE_DEPTH) - used_wide;
    assign fill_mark = (CW+LW)'(s_q.fill_threshold_level) * (CW+LW)'(host_port_pkg::LEVEL_STEP);
    assign drain_mark = (CW+LW)'(s_q.drain_threshold_level) * (CW+LW)'(host_port_pkg::LEVEL_STEP);

    always_comb begin
        if (s_q.mode_encode) begin
            service_now = (s_q.fill_threshold_level != '0) && (used_wide >= fill_mark);
            halt_now = (q_count == '0);
            fault_now = i_core_wvalid && !q_in_ready;
        end else begin
            service_now = (s_q.drain_threshold_level != '0) && (free_wide >= drain_mark);
            // early full: host still has room for the margin after this rises
            halt_now = free_wide <= (CW+LW)'(host_port_pkg::HALT_MARGIN);
            fault_now = (i_core_rready && !q_out_valid) || (stream_push && !q_in_ready);
        end
    end

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    logic [NE-1:0] cond;
    logic [NE-1:0] rise;
    logic [NE-1:0] live;
    logic [15:0] status_word;

    always_comb begin
        cond = '0;
        cond[host_port_pkg::EVT_SYNC] = i_sync_code_error;
        cond[host_port_pkg::EVT_STATS] = i_stats_ready;
        cond[host_port_pkg::EVT_FINAL] = i_final_word;
        cond[host_port_pkg::EVT_SERVICE] = service_now;
        cond[host_port_pkg::EVT_FAULT] = fault_now;
        cond[host_port_pkg::EVT_HALT] = halt_now;
        cond[host_port_pkg::EVT_MEM] = i_memory_fault;
    end

    assign rise = cond & ~s_q.cond_prev;

    // status view: service bit is the live level, others the sticky flags
    always_comb begin
        live = s_q.flags;
        live[host_port_pkg::EVT_SERVICE] = service_now;
        status_word = '0;
        status_word[NE-1:0] = live;
        status_word[host_port_pkg::EN_LSB +: NE] = s_q.enables;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [15:0] window_read;
    logic window_is_ctl;
    logic window_is_mode;

    assign window_is_ctl = (s_q.index_value == host_port_pkg::IDX_FIFO_CTL);
    assign window_is_mode = (s_q.index_value == host_port_pkg::IDX_MODE);
    always_comb begin
        window_read = i_window_value;
        if (window_is_ctl) begin
            window_read = '0;
            window_read[host_port_pkg::CTL_FILL_LSB +: LW] = s_q.fill_threshold_level;
            window_read[host_port_pkg::CTL_DRAIN_LSB +: LW] = s_q.drain_threshold_level;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.rvalid = i_host_rd;
        s_d.cond_prev = cond;
        if (hit_index_wr) begin
            s_d.index_value = i_host_wdata[host_port_pkg::IND_W-1:0];
        end
        if (hit_window) begin
            s_d.index_value = s_q.index_value + 16'h0001;
        end
        if (hit_window && i_host_wr && window_is_mode) begin
            s_d.mode_encode = i_host_wdata[host_port_pkg::MODE_ENCODE_BIT];
            s_d.irq_polarity_select = i_host_wdata[host_port_pkg::MODE_IRQ_POL_BIT];
        end
        if (hit_window && i_host_wr && window_is_ctl) begin
            s_d.fill_threshold_level = i_host_wdata[host_port_pkg::CTL_FILL_LSB +: LW];
            s_d.drain_threshold_level = i_host_wdata[host_port_pkg::CTL_DRAIN_LSB +: LW];
        end
        if (hit_stream_wr && low_only) begin
            s_d.low_half = i_host_wdata[15:0];
        end
        if (hit_irq_wr && i_host_be[1]) begin
            s_d.enables = i_host_wdata[host_port_pkg::EN_LSB +: NE];
        end
        // clear on read first, then new rises win over the clear
        if (hit_irq_rd) begin
            s_d.flags = '0;
        end
        s_d.flags = s_d.flags | rise;
        s_d.flags[host_port_pkg::EVT_SERVICE] = 1'b0;
        // read data
        s_d.rdata = '0;
        if (i_host_rd) begin
            unique case (i_host_addr)
                host_port_pkg::OFS_WINDOW: s_d.rdata = {16'h0000, window_read};
                host_port_pkg::OFS_STREAM: s_d.rdata = q_out_data;
                host_port_pkg::OFS_IRQ: s_d.rdata = {16'h0000, status_word};
                default: s_d.rdata = '0;
            endcase
        end
        // pins
        s_d.irq_pin = (|(live & s_q.enables)) ~^ s_q.irq_polarity_select;
        s_d.stats_pin = i_stats_ready;
        s_d.final_pin = i_final_word;
        s_d.service_pin = service_now;
        s_d.halt_pin = halt_now;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q <= '0;
            s_q.mode_encode <= host_port_pkg::MODE_ENCODE_RST;
            s_q.irq_polarity_select <= host_port_pkg::IRQ_POL_RST;
            s_q.fill_threshold_level <= host_port_pkg::FILL_LEVEL_RST;
            s_q.drain_threshold_level <= host_port_pkg::DRAIN_LEVEL_RST;
            s_q.irq_pin <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_host_rdata = s_q.rdata;
    assign o_host_rvalid = s_q.rvalid;
    assign o_index_value = s_q.index_value;
    assign o_ind_wr = hit_window && i_host_wr;
    assign o_ind_rd = hit_window && i_host_rd;
    assign o_window_value = i_host_wdata[host_port_pkg::IND_W-1:0];
    assign o_encode_mode = s_q.mode_encode;
    assign o_host_irq_pin = s_q.irq_pin;
    assign o_stats_ready_pin = s_q.stats_pin;
    assign o_final_word_pin = s_q.final_pin;
    assign o_service_request_pin = s_q.service_pin;
    assign o_queue_fault_pin = s_q.flags[host_port_pkg::EVT_FAULT];
    assign o_queue_halt_pin = s_q.halt_pin;
endmodule

`default_nettype wire

/* File: host_port_monitor.sv */
// host_port_monitor: timing relations at the host port pins.
// assumes: bound into host_port_regs_and_irq, single clock, async reset.
`timescale 1ns/100ps
`default_nettype none
module host_port_monitor (
    // clock, reset and host bus
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [3:0] i_host_addr,
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    input wire logic [3:0] i_host_be,
    input wire logic [31:0] i_host_wdata,
    input wire logic [31:0] o_host_rdata,
    // core side and pins
    input wire logic [15:0] o_index_value,
    input wire logic o_ind_wr,
    input wire logic [15:0] o_window_value,
    input wire logic [15:0] i_window_value,
    input wire logic i_core_wvalid,
    input wire logic o_core_wready,
    input wire logic o_core_rvalid,
    input wire logic i_stats_ready,
    input wire logic o_stats_ready_pin,
    input wire logic o_encode_mode,
    input wire logic o_queue_fault_pin
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic win_acc;
    logic irq_rd;
    assign win_acc = (i_host_wr || i_host_rd) && i_host_addr == host_port_pkg::OFS_WINDOW;
    assign irq_rd = i_host_rd && i_host_addr == host_port_pkg::OFS_IRQ;
    window_data_a: assert property (i_host_rd && win_acc && o_index_value != 16'h0001 |=>
        o_host_rdata == {16'h0000, $past(i_window_value)}) else $error("window data wrong");
    index_step_a: assert property (win_acc |=>
        o_index_value == $past(o_index_value) + 16'h0001) else $error("index not stepped");
    index_load_a: assert property (i_host_wr && i_host_be == 4'hf && i_host_addr == 4'h0 |=>
        o_index_value == $past(i_host_wdata[15:0])) else $error("index not loaded");
    window_out_a: assert property (o_ind_wr |-> i_host_wr &&
        o_window_value == i_host_wdata[15:0]) else $error("window write value wrong");
    irq_reserved_a: assert property (irq_rd |=> !o_host_rdata[7] && !o_host_rdata[15] &&
        o_host_rdata[31:16] == 16'h0000) else $error("reserved status bits set");
    stats_pin_a: assert property (o_stats_ready_pin == $past(i_stats_ready))
        else $error("stats pin does not follow");
    fault_hold_a: assert property (o_queue_fault_pin && !irq_rd && !$past(irq_rd) |=>
        o_queue_fault_pin) else $error("fault flag lost without read");
    overflow_fault_a: assert property (o_encode_mode && i_core_wvalid && !o_core_wready
        |-> ##[1:2] o_queue_fault_pin) else $error("overflow not flagged");
    mode_gate_a: assert property (o_encode_mode ? !o_core_rvalid : !o_core_wready)
        else $error("stream open in wrong mode");
    cover property (irq_rd ##1 o_host_rdata[0]);
    cover property ($rose(o_queue_fault_pin));
    cover property (i_host_wr && i_host_be == host_port_pkg::BE_HIGH_HALF);
endmodule
bind host_port_regs_and_irq host_port_monitor mon (.i_clk, .i_reset, .i_host_addr, .i_host_wr,
    .i_host_rd, .i_host_be, .i_host_wdata, .o_host_rdata, .o_index_value, .o_ind_wr,
    .o_window_value, .i_window_value, .i_core_wvalid, .o_core_wready, .o_core_rvalid,
    .i_stats_ready, .o_stats_ready_pin, .o_encode_mode, .o_queue_fault_pin);
`default_nettype wire

/* File: core_far_model.sv */
// core_far_model: codec core behind the port: window data and streams.
// assumes: same clock and reset as the host port.
`timescale 1ns/100ps
`default_nettype none
module core_far_model (
    // clock, reset and window
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [15:0] i_index_value,
    input wire logic i_ind_rd,
    output logic [15:0] o_window_value,
    // streams
    output logic o_wvalid,
    input wire logic i_wready,
    output logic [31:0] o_wdata,
    input wire logic i_rvalid,
    output logic o_rready,
    // control from the bench
    input wire logic [15:0] i_target,
    input wire logic i_take,
    output logic [15:0] o_sent,
    output logic [15:0] o_taken
);
    logic [15:0] ans;
    logic [31:0] word;
    // inverted outside the sample cycle so a stale capture shows
    assign ans = i_index_value ^ 16'h5a5a;
    assign o_window_value = i_ind_rd ? ans : ~ans;
    assign o_wvalid = o_sent < i_target;
    assign word = 32'hc000_1000 + {16'h0000, o_sent};
    assign o_wdata = o_wvalid ? word : ~word;
    assign o_rready = i_take;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_sent <= 16'h0000;
            o_taken <= 16'h0000;
        end else begin
            o_sent <= o_sent + 16'(o_wvalid && i_wready);
            o_taken <= o_taken + 16'(i_rvalid && i_take);
        end
    end
endmodule
`default_nettype wire

/* File: host_port_regs_and_irq_bench.sv */
// host_port_regs_and_irq_bench: directed scenarios for the host port.
// assumes: core_far_model at the core side, monitor bound to uut.
`timescale 1ns/100ps
`default_nettype none
module host_port_regs_and_irq_bench;
    // small queue keeps fill and drain loops short
    localparam int DEPTH = 64;
    logic i_clk, i_reset, i_host_wr, i_host_rd, o_host_rvalid, o_ind_wr, o_ind_rd;
    logic [3:0] i_host_addr, i_host_be, ev;
    logic [31:0] i_host_wdata, o_host_rdata, i_core_wdata, o_core_rdata, d;
    logic [15:0] o_index_value, o_window_value, i_window_value, target, sent, taken;
    logic i_core_wvalid, o_core_wready, o_core_rvalid, i_core_rready, take;
    logic i_sync_code_error, i_stats_ready, i_final_word, i_memory_fault;
    logic o_encode_mode, o_host_irq_pin, o_stats_ready_pin, o_final_word_pin;
    logic o_service_request_pin, o_queue_fault_pin, o_queue_halt_pin;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int pos[4] = '{0, 1, 2, 6};
    assign {i_memory_fault, i_final_word, i_stats_ready, i_sync_code_error} = ev;
    host_port_regs_and_irq #(.QUEUE_DEPTH(DEPTH)) uut (.i_clk, .i_reset, .i_host_addr,
        .i_host_wr, .i_host_rd, .i_host_be, .i_host_wdata, .o_host_rdata, .o_host_rvalid,
        .o_index_value, .o_ind_wr, .o_ind_rd, .o_window_value, .i_window_value, .i_core_wvalid,
        .o_core_wready, .i_core_wdata, .o_core_rvalid, .i_core_rready, .o_core_rdata,
        .i_sync_code_error, .i_stats_ready, .i_final_word, .i_memory_fault, .o_encode_mode,
        .o_host_irq_pin, .o_stats_ready_pin, .o_final_word_pin, .o_service_request_pin,
        .o_queue_fault_pin, .o_queue_halt_pin);
    core_far_model far (.i_clk, .i_reset, .i_index_value(o_index_value), .i_ind_rd(o_ind_rd),
        .o_window_value(i_window_value), .o_wvalid(i_core_wvalid), .i_wready(o_core_wready),
        .o_wdata(i_core_wdata), .i_rvalid(o_core_rvalid), .o_rready(i_core_rready),
        .i_target(target), .i_take(take), .o_sent(sent), .o_taken(taken));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [3:0] b, input logic [31:0] v);
        @(posedge i_clk);
        i_host_addr <= a;
        i_host_be <= b;
        i_host_wdata <= v;
        i_host_wr <= 1'b1;
        @(posedge i_clk);
        i_host_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [3:0] b);
        @(posedge i_clk);
        i_host_addr <= a;
        i_host_be <= b;
        i_host_rd <= 1'b1;
        @(posedge i_clk);
        i_host_rd <= 1'b0;
        #1;
        d = o_host_rdata;
        chk(o_host_rvalid === 1'b1, "no read answer");
    endtask
    task automatic ind(input logic [15:0] i, input logic [15:0] v);
        wr(4'h0, 4'hf, {16'h0000, i});
        wr(4'h4, 4'hf, {16'h0000, v});
    endtask
    task automatic t_reset_window;
        rd(4'hc, 4'hf);
        chk((d & 32'hffff_ffdf) === 32'h0, "status not clear");
        chk(o_host_irq_pin === 1'b1, "irq pin not idle");
        wr(4'h0, 4'hf, 32'h0000_0002);
        chk(o_index_value === 16'h0002, "index not loaded");
        wr(4'h4, 4'hf, 32'h0000_1234);
        chk(o_index_value === 16'h0003, "no step on write");
        rd(4'h4, 4'hf);
        chk(d === {16'h0000, 16'h0003 ^ 16'h5a5a}, "window read wrong");
        chk(o_index_value === 16'h0004, "no step on read");
        $display("test window done");
    endtask
    task automatic t_encode;
        ind(host_port_pkg::IDX_FIFO_CTL, 16'h0020);
        wr(4'h0, 4'hf, {16'h0000, host_port_pkg::IDX_FIFO_CTL});
        rd(4'h4, 4'hf);
        chk(d[15:0] === 16'h0020, "levels not read back");
        @(posedge i_clk);
        target <= 16'd40;
        tick(60);
        chk(sent === 16'd40 && o_service_request_pin === 1'b0, "level zero serviced");
        chk(o_queue_halt_pin === 1'b0, "halt with data");
        ind(host_port_pkg::IDX_FIFO_CTL, 16'h0021);
        tick(2);
        chk(o_service_request_pin === 1'b1, "no service at level");
        repeat (2) begin
            rd(4'hc, 4'hf);
            chk(d[3] === 1'b1, "service bit not live");
        end
        @(posedge i_clk);
        target <= 16'(DEPTH + 1);
        tick(DEPTH);
        chk(sent === 16'(DEPTH), "queue did not refuse");
        chk(o_queue_fault_pin === 1'b1, "no overflow fault");
        @(posedge i_clk);
        target <= 16'(DEPTH);
        rd(4'h8, 4'h3);
        chk(d[15:0] === 16'h1000, "half read wrong");
        for (int i = 0; i < DEPTH; i++) begin
            rd(4'h8, 4'hf);
            chk(d === 32'hc000_1000 + i, "stream word wrong");
        end
        tick(2);
        chk(o_queue_halt_pin === 1'b1, "no halt when empty");
        $display("test encode done");
    endtask
    task automatic t_decode;
        rd(4'hc, 4'hf);
        ind(host_port_pkg::IDX_MODE, 16'h0000);
        chk(o_encode_mode === 1'b0 && o_queue_fault_pin === 1'b0, "mode or fault");
        wr(4'h8, 4'h3, 32'h0000_beef);
        wr(4'h8, 4'hc, 32'hcafe_0000);
        chk(o_core_rvalid === 1'b1 && o_core_rdata === 32'hcafe_beef, "halves unpaired");
        for (int i = 1; i < 31; i++) begin
            wr(4'h8, 4'hf, i);
        end
        tick(1);
        chk(o_queue_halt_pin === 1'b0, "halt too early");
        wr(4'h8, 4'hf, 32'h0000_0031);
        tick(1);
        chk(o_queue_halt_pin === 1'b1, "no halt at margin");
        for (int i = 0; i < 32; i++) begin
            wr(4'h8, 4'hf, i);
        end
        chk(o_queue_fault_pin === 1'b0, "fault within margin");
        wr(4'h8, 4'hf, 32'h0000_ffff);
        tick(2);
        chk(o_queue_fault_pin === 1'b1, "excess write not flagged");
        @(posedge i_clk);
        take <= 1'b1;
        tick(DEPTH + 8);
        chk(taken === 16'(DEPTH) && o_service_request_pin === 1'b1, "drain wrong");
        @(posedge i_clk);
        take <= 1'b0;
        $display("test decode done");
    endtask
    task automatic t_events;
        ind(host_port_pkg::IDX_MODE, 16'h0080);
        for (int k = 0; k < 4; k++) begin
            wr(4'hc, 4'hf, 32'h0000_0001 << (8 + pos[k]));
            rd(4'hc, 4'hf);
            @(posedge i_clk);
            ev[k] <= 1'b1;
            tick(3);
            chk(o_host_irq_pin === 1'b0 && o_final_word_pin === ev[2], "no irq");
            rd(4'hc, 4'hf);
            chk(d[pos[k]] === 1'b1, "flag not set");
            rd(4'hc, 4'hf);
            tick(1);
            chk(d[pos[k]] === 1'b0 && o_host_irq_pin === 1'b1, "set by level");
            @(posedge i_clk);
            ev[k] <= 1'b0;
        end
        @(posedge i_clk);
        ev[0] <= 1'b1;
        i_host_addr <= 4'hc;
        i_host_rd <= 1'b1;
        @(posedge i_clk);
        i_host_rd <= 1'b0;
        rd(4'hc, 4'hf);
        chk(d[0] === 1'b1, "rise lost in read");
        ind(host_port_pkg::IDX_MODE, 16'h2080);
        tick(2);
        chk(o_host_irq_pin === 1'b0, "high polarity idle");
        @(posedge i_clk);
        ev[3] <= 1'b1;
        tick(3);
        chk(o_host_irq_pin === 1'b1, "high polarity irq");
        $display("test events done");
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            $display("[FAIL] %0t run hung", $time);
            print_verdict;
        end
    end
    initial begin
        i_reset = 1'b1;
        i_host_wr = 1'b0;
        i_host_rd = 1'b0;
        i_host_addr = 4'h0;
        i_host_be = 4'hf;
        i_host_wdata = 32'h0;
        ev = 4'h0;
        target = 16'h0000;
        take = 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset_window;
        t_encode;
        t_decode;
        t_events;
        print_verdict;
    end
endmodule
`default_nettype wire
